//--- rtl/vpr_regs.vh
// Constants for the vital product data page responder
// Contract
// R1: Initiator picks a page by INQUIRY with EVPD set and a page code.
// R2: Byte 0 of every page is zero: qualifier and device type both zero.
// R3: Byte 1 echoes the page code; supported codes are 8Ah, 8Dh, 90h.
// R4: Power-condition page reports page length 14 in bytes 2-3.
// R5: Support flags set per enterable condition; y,z in byte 4; c,b,a byte 5.
// R6: Six 16-bit recovery timers in ms at bytes 6 through 17.
// R7: Recovery times cover only the return to active, not command processing.
// R8: Timer zero means unspecified; FFFFh means longer than 65.534 seconds.
// R9: Power-consumption page reports page length 4 in bytes 2-3.
// R10: Consumption identifier byte 4 is zero.
// R11: Units field in low bits of byte 5 is 4 (milliwatts), upper bits zero.
// R12: Maximum power consumption sits in the 16-bit field at bytes 6-7.
// R13: Logical unit page length 24, descriptors at bytes 4-15 and 16-27.
// R14: Relative port identifier is 1 for primary and 2 for secondary port.
// R15: Protocol identifier 6h in byte 2 low nibble; descriptor length 0004h.
// R16: Retry control capable field is zero in each descriptor.
// R17: Reserved bits are zero; multi-byte fields go most significant byte first.
// R18: Page truncated to allocation length; full page length still reported.
`ifndef VPR_REGS_VH
`define VPR_REGS_VH

`define VPR_PAGE_PWR_COND     8'h8A
`define VPR_PAGE_PWR_USE      8'h8D
`define VPR_PAGE_LU_INFO      8'h90
`define VPR_LEN_PWR_COND      16'h000E
`define VPR_LEN_PWR_USE       16'h0004
`define VPR_LEN_LU_INFO       16'h0018
`define VPR_PWR_UNITS_MW      8'h04
`define VPR_PROTO_SAS         8'h06
`define VPR_DESC_LEN          16'h0004
`define VPR_PORT_PRI          16'h0001
`define VPR_PORT_SEC          16'h0002
`define VPR_HDR_BYTES         6'h04
`define VPR_DESC1_OFS         6'h10

// AXI4-Lite register byte addresses
`define VPR_A_CTRL            12'h000
`define VPR_A_STATUS          12'h004
`define VPR_A_FLAGS           12'h008
`define VPR_A_TMR_STOP_Z      12'h00C
`define VPR_A_TMR_Y_A         12'h010
`define VPR_A_TMR_B_C         12'h014
`define VPR_A_POWER           12'h018

// Control and status register fields
`define VPR_CTRL_START        0
`define VPR_CTRL_EVPD         1
`define VPR_CTRL_CODE_LO      8
`define VPR_CTRL_ALLOC_LO     16
`define VPR_STAT_DONE         2

// Reset values
`define VPR_RST_FLAGS         16'h0000
`define VPR_RST_TMR           32'h0000_0000
`define VPR_RST_POWER         16'h0000

`define VPR_RESP_OKAY         2'b00
`define VPR_RESP_SLVERR       2'b10

`define VPR_FIFO_DEPTH        8
`define VPR_FIFO_AW           3

`endif

//--- rtl/vpr_fifo.v
// Byte FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module vpr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_reg;
	reg [AW-1:0]    rd_reg;
	reg [AW:0]      cnt_reg;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rd_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg  <= {AW{1'b0}};
			rd_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // vpr_fifo
`default_nettype wire

//--- rtl/vpr_page_responder.v
// Vital product data page responder with AXI4-Lite setup and byte stream out
`timescale 1ns/100ps
`default_nettype none
`include "vpr_regs.vh"
module vpr_page_responder (
	input  wire        clk,
	input  wire        resetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [7:0]  page_data,
	output reg         page_valid,
	output reg         page_last,
	input  wire        page_ready
);
	reg        rst_meta_reg;
	reg        rst_n_reg;
	wire       gen_ready;
	wire       page_fire;

	// Two-flop release so every register reset by rst_n_reg leaves reset on one edge, clear of resetn
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// Page contents set by firmware, then request and stream state
	reg [15:0] flags_reg;
	reg [31:0] tmr_sz_reg;
	reg [31:0] tmr_ya_reg;
	reg [31:0] tmr_bc_reg;
	reg [15:0] power_reg;
	reg [7:0]  code_reg;
	reg [15:0] alloc_reg;
	reg        busy_reg;
	reg        bad_reg;
	reg        done_reg;
	reg [5:0]  idx_reg;
	reg [5:0]  end_reg;

	// Length field of a page, bytes after byte 3
	function [15:0] page_len;
		input [7:0] code;
		begin
			if (code == `VPR_PAGE_PWR_COND) begin
				page_len = `VPR_LEN_PWR_COND;
			end else if (code == `VPR_PAGE_PWR_USE) begin
				page_len = `VPR_LEN_PWR_USE;
			end else begin
				page_len = `VPR_LEN_LU_INFO;
			end
		end
	endfunction

	function at_last;
		input [5:0] i;
		input [5:0] n;
		begin
			at_last = (i == n - 6'd1);
		end
	endfunction

	// Allocation length capped at the full page; a short buffer gets a cut page
	function [15:0] clamp_len;
		input [15:0] alloc;
		input [15:0] full;
		begin
			clamp_len = (alloc < full) ? alloc : full;
		end
	endfunction

	// Registers are whole aligned words, so the byte lane bits are dropped
	function [11:0] word_addr;
		input [11:0] a;
		begin
			word_addr = {a[11:2], 2'b00};
		end
	endfunction

	// Byte of the selected page at a given index, reserved bytes zero
	function [7:0] page_byte;
		input [7:0] code;
		input [5:0] i;
		reg   [5:0] d;
		reg   [15:0] len;
		reg   [15:0] port;
		reg   [15:0] dlen;
		begin
			page_byte = 8'h00;
			d = 6'h00;
			port = `VPR_PORT_PRI;
			dlen = `VPR_DESC_LEN;
			len = page_len(code);
			case (i)
				6'd0: page_byte = 8'h00; // R2
				6'd1: page_byte = code; // R3
				6'd2: page_byte = len[15:8]; // R17
				6'd3: page_byte = len[7:0]; // R4 R9 R13
				default: page_byte = 8'h00;
			endcase
			if (i >= `VPR_HDR_BYTES) begin
				if (code == `VPR_PAGE_PWR_COND) begin
					// Recovery timers exclude command processing time and 0 is unspecified
					case (i)
						6'd4: page_byte = {6'h00, flags_reg[9:8]}; // R5
						6'd5: page_byte = {5'h00, flags_reg[2:0]}; // R5
						6'd6: page_byte = tmr_sz_reg[31:24]; // R6 R7 R8
						6'd7: page_byte = tmr_sz_reg[23:16]; // R6
						6'd8: page_byte = tmr_sz_reg[15:8]; // R6
						6'd9: page_byte = tmr_sz_reg[7:0]; // R6
						6'd10: page_byte = tmr_ya_reg[31:24]; // R6
						6'd11: page_byte = tmr_ya_reg[23:16]; // R6
						6'd12: page_byte = tmr_ya_reg[15:8]; // R6
						6'd13: page_byte = tmr_ya_reg[7:0]; // R6
						6'd14: page_byte = tmr_bc_reg[31:24]; // R6
						6'd15: page_byte = tmr_bc_reg[23:16]; // R6
						6'd16: page_byte = tmr_bc_reg[15:8]; // R6
						6'd17: page_byte = tmr_bc_reg[7:0]; // R6
						default: page_byte = 8'h00;
					endcase
				end else if (code == `VPR_PAGE_PWR_USE) begin
					case (i)
						6'd4: page_byte = 8'h00; // R10
						6'd5: page_byte = `VPR_PWR_UNITS_MW; // R11
						6'd6: page_byte = power_reg[15:8]; // R12
						6'd7: page_byte = power_reg[7:0]; // R12
						default: page_byte = 8'h00;
					endcase
				end else begin
					// Second descriptor repeats the first with the secondary port number
					d = (i >= `VPR_DESC1_OFS) ? i - `VPR_DESC1_OFS : i - `VPR_HDR_BYTES;
					port = (i >= `VPR_DESC1_OFS) ? `VPR_PORT_SEC : `VPR_PORT_PRI;
					case (d)
						6'd0: page_byte = port[15:8]; // R14
						6'd1: page_byte = port[7:0]; // R14
						6'd2: page_byte = `VPR_PROTO_SAS; // R15
						6'd6: page_byte = dlen[15:8]; // R15
						6'd7: page_byte = dlen[7:0]; // R15
						6'd8: page_byte = 8'h00; // R16
						default: page_byte = 8'h00;
					endcase
				end
			end
		end
	endfunction

	function [5:0] page_total;
		input [7:0] code;
		reg   [15:0] sum;
		begin
			sum = page_len(code) + {10'h000, `VPR_HDR_BYTES};
			page_total = sum[5:0];
		end
	endfunction

	function is_supported;
		input [7:0] code;
		begin
			is_supported = (code == `VPR_PAGE_PWR_COND) || (code == `VPR_PAGE_PWR_USE) ||
			               (code == `VPR_PAGE_LU_INFO); // R3
		end
	endfunction

	// AXI4-Lite write: address and data may arrive in either order
	reg        aw_have_reg;
	reg        w_have_reg;
	reg [11:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	wire       wr_go;
	wire       start_req;
	wire [7:0] req_code;
	wire [15:0] req_alloc;
	wire [15:0] full_len;
	wire [15:0] send_len;

	assign wr_go     = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	assign start_req = wr_go && (aw_addr_reg == `VPR_A_CTRL) &&
	                   w_data_reg[`VPR_CTRL_START] && (&w_strb_reg) && !busy_reg;
	assign req_code  = w_data_reg[`VPR_CTRL_CODE_LO +: 8];
	assign req_alloc = w_data_reg[`VPR_CTRL_ALLOC_LO +: 16];
	assign full_len  = {10'h000, page_total(req_code)};
	assign send_len  = clamp_len(req_alloc, full_len);

	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `VPR_RESP_OKAY;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 12'h000;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			flags_reg     <= `VPR_RST_FLAGS;
			tmr_sz_reg    <= `VPR_RST_TMR;
			tmr_ya_reg    <= `VPR_RST_TMR;
			tmr_bc_reg    <= `VPR_RST_TMR;
			power_reg     <= `VPR_RST_POWER;
			code_reg      <= 8'h00;
			alloc_reg     <= 16'h0000;
			bad_reg       <= 1'b0;
			done_reg      <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= word_addr(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `VPR_RESP_OKAY;
				case (aw_addr_reg)
					`VPR_A_CTRL: begin
						if (start_req) begin
							// Unsupported or non-EVPD requests are flagged and stream nothing
							bad_reg  <= !w_data_reg[`VPR_CTRL_EVPD] || !is_supported(req_code); // R1
							done_reg <= 1'b0;
							code_reg <= req_code;
							// Stream stops at allocation length; length fields stay full
							alloc_reg <= send_len; // R18
						end
					end
					`VPR_A_STATUS: begin
						if (w_strb_reg[0] && w_data_reg[`VPR_STAT_DONE]) begin
							done_reg <= 1'b0;
						end
					end
					`VPR_A_FLAGS: begin
						if (w_strb_reg[0]) flags_reg[7:0] <= w_data_reg[7:0];
						if (w_strb_reg[1]) flags_reg[15:8] <= w_data_reg[15:8];
					end
					`VPR_A_TMR_STOP_Z: tmr_sz_reg <= w_data_reg;
					`VPR_A_TMR_Y_A: tmr_ya_reg <= w_data_reg;
					`VPR_A_TMR_B_C: tmr_bc_reg <= w_data_reg;
					`VPR_A_POWER: begin
						if (w_strb_reg[0]) power_reg[7:0] <= w_data_reg[7:0];
						if (w_strb_reg[1]) power_reg[15:8] <= w_data_reg[15:8];
					end
					default: s_axi_bresp <= `VPR_RESP_SLVERR;
				endcase
			end
			// Completion set wins over the software clear in the same cycle
			if (page_fire && at_last(idx_reg, end_reg)) begin
				done_reg <= 1'b1;
			end
		end
	end

	// AXI4-Lite read; arready stays low while an answer waits for rready
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `VPR_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `VPR_RESP_OKAY;
				case (word_addr(s_axi_araddr))
					`VPR_A_CTRL: s_axi_rdata <= {alloc_reg, code_reg, 8'h00};
					`VPR_A_STATUS: s_axi_rdata <= {26'h0, idx_reg[5:3], done_reg, bad_reg, busy_reg};
					`VPR_A_FLAGS: s_axi_rdata <= {16'h0000, flags_reg};
					`VPR_A_TMR_STOP_Z: s_axi_rdata <= tmr_sz_reg;
					`VPR_A_TMR_Y_A: s_axi_rdata <= tmr_ya_reg;
					`VPR_A_TMR_B_C: s_axi_rdata <= tmr_bc_reg;
					`VPR_A_POWER: s_axi_rdata <= {16'h0000, power_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `VPR_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Byte generator feeding the FIFO; stalls when the FIFO is full
	wire [7:0] f_data;
	wire       f_valid;
	wire       f_ready;

	assign page_fire = busy_reg & gen_ready;

	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			busy_reg <= 1'b0;
			idx_reg  <= 6'h00;
			end_reg  <= 6'h00;
		end else if (!busy_reg) begin
			if (start_req && w_data_reg[`VPR_CTRL_EVPD] && is_supported(req_code) &&
			    req_alloc != 16'h0000) begin
				busy_reg <= 1'b1;
				idx_reg  <= 6'h00;
				end_reg  <= send_len[5:0]; // R18
			end
		end else if (page_fire) begin
			idx_reg <= idx_reg + 6'd1;
			if (at_last(idx_reg, end_reg)) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// Last marker travels as the ninth FIFO bit
	wire [8:0] f_out;
	vpr_fifo #(
		.WIDTH (9),
		.DEPTH (`VPR_FIFO_DEPTH),
		.AW    (`VPR_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n_reg),
		.in_data   ({at_last(idx_reg, end_reg), page_byte(code_reg, idx_reg)}), // R17
		.in_valid  (busy_reg),
		.in_ready  (gen_ready),
		.out_data  (f_out),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);
	assign f_data  = f_out[7:0];
	assign f_ready = ~page_valid | page_ready;

	// Registered output stage
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			page_valid <= 1'b0;
			page_data  <= 8'h00;
			page_last  <= 1'b0;
		end else if (f_ready) begin
			page_valid <= f_valid;
			page_data  <= f_valid ? f_data : 8'h00;
			page_last  <= f_valid & f_out[8];
		end
	end
endmodule // vpr_page_responder
`default_nettype wire

//--- testbench/vpr_page_responder_properties.sv
// Port assertions for the page responder
`timescale 1ns/100ps
`default_nettype none
module vpr_props (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [7:0] page_data,
	input wire logic       page_valid,
	input wire logic       page_last,
	input wire logic       page_ready
);
	logic [5:0] idx;
	logic [7:0] code;
	// Offset inside the current descriptor; only meaningful past the header
	wire  [5:0] j = idx >= 6'h10 ? idx - 6'h10 : idx - 6'h04;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idx  <= 6'h00;
			code <= 8'h00;
		end else if (page_valid && page_ready) begin
			idx <= page_last ? 6'h00 : idx + 6'h01;
			if (idx == 6'h01)
				code <= page_data;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped before bready");
	byte_hold_a: assert property (page_valid && !page_ready |=>
		page_valid && $stable(page_data) && $stable(page_last))
		else $error("page byte changed while stalled");
	hdr_zero_a: assert property (
		page_valid && idx inside {6'h00, 6'h02} |-> page_data == 8'h00)
		else $error("header byte not zero");
	code_ok_a: assert property (
		page_valid && idx == 6'h01 |-> page_data inside {8'h8A, 8'h8D, 8'h90})
		else $error("page code not supported");
	len_lo_a: assert property (
		page_valid && idx == 6'h03 |->
		page_data == (code == 8'h8A ? 8'h0E : code == 8'h8D ? 8'h04 : 8'h18))
		else $error("page length wrong");
	use_hdr_a: assert property (
		page_valid && code == 8'h8D && idx inside {6'h04, 6'h05} |->
		page_data == (idx == 6'h05 ? 8'h04 : 8'h00))
		else $error("consumption header wrong");
	lu_port_a: assert property (
		page_valid && code == 8'h90 && idx > 6'h03 && j == 6'h01 |->
		page_data == (idx < 6'h10 ? 8'h01 : 8'h02))
		else $error("relative port wrong");
	lu_desc_a: assert property (
		page_valid && code == 8'h90 && idx > 6'h03 && j != 6'h01 |->
		page_data == (j == 6'h02 ? 8'h06 : j == 6'h07 ? 8'h04 : 8'h00))
		else $error("descriptor byte wrong");
endmodule // vpr_props

bind vpr_page_responder vpr_props vpr_props_inst (
	.clk, .resetn, .s_axi_bvalid, .s_axi_bready,
	.page_data, .page_valid, .page_last, .page_ready
);
`default_nettype wire

//--- testbench/vpr_sink.sv
// Initiator-side page byte sink with selectable pacing
`timescale 1ns/100ps
`default_nettype none
module vpr_sink (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic [1:0] mode,
	input wire logic       clr,
	input wire logic [7:0] page_data,
	input wire logic       page_valid,
	input wire logic       page_last,
	output logic           page_ready,
	output logic [5:0]     cnt,
	output logic           seen_last
);
	logic [7:0] got [0:63];
	// Mode 0 takes every byte, 1 every other cycle, 2 stalls.
	// Bytes after the last one are still counted so overruns show.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			page_ready <= 1'b0;
			cnt        <= 6'h00;
			seen_last  <= 1'b0;
		end else begin
			page_ready <= mode == 2'h0 || (mode == 2'h1 && !page_ready);
			if (clr) begin
				cnt       <= 6'h00;
				seen_last <= 1'b0;
			end else if (page_valid && page_ready) begin
				got[cnt]  <= page_data;
				cnt       <= cnt + 6'h01;
				seen_last <= seen_last | page_last;
			end
		end
	end
endmodule // vpr_sink
`default_nettype wire

//--- testbench/test_vpr_page_responder.sv
// Self-checking bench for the page responder
`timescale 1ns/100ps
`default_nettype none
`include "vpr_regs.vh"
module test_vpr_page_responder;
	logic        clk = 1'b0, resetn = 1'b0, clr = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0]  mode = 2'h0;
	wire         awready, wready, bvalid, arready, rvalid, pv, pl, pr, seen_last;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  pd;
	wire  [5:0]  cnt;
	int          err_total = 0;
	int          num_checks = 0;
	logic [7:0]  exp [0:27];
	logic [31:0] rv [0:4] = '{32'h0000_0205, 32'hFFFF_0000, 32'h1234_00A5,
		32'h0001_C3B2, 32'h0000_2EE0};
	vpr_page_responder vpr_page_responder_inst (
		.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .page_data(pd),
		.page_valid(pv), .page_last(pl), .page_ready(pr)
	);
	vpr_sink vpr_sink_inst (
		.clk(clk), .resetn(resetn), .mode(mode), .clr(clr), .page_data(pd),
		.page_valid(pv), .page_last(pl), .page_ready(pr), .cnt(cnt), .seen_last(seen_last)
	);
	always #25 clk = ~clk;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic hang;
		err_total++;
		$display("ERROR wait expected answer seen none");
		finish_test;
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (k == 60) hang;
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (k == 60) hang;
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	function automatic int build(input logic [7:0] c);
		int i;
		logic [15:0] t;
		for (i = 0; i < 28; i++) exp[i] = 8'h00;
		exp[1] = c;
		if (c == 8'h8A) begin
			exp[3] = 8'h0E;
			exp[4] = {6'h00, rv[0][9:8]};
			exp[5] = {5'h00, rv[0][2:0]};
			for (i = 0; i < 6; i++) begin
				t = i[0] ? rv[1 + i / 2][15:0] : rv[1 + i / 2][31:16];
				exp[6 + 2 * i] = t[15:8];
				exp[7 + 2 * i] = t[7:0];
			end
			return 18;
		end
		if (c == 8'h8D) begin
			exp[3] = 8'h04;
			exp[5] = 8'h04;
			exp[6] = rv[4][15:8];
			exp[7] = rv[4][7:0];
			return 8;
		end
		exp[3] = 8'h18;
		for (i = 0; i < 2; i++) begin
			exp[5 + 12 * i] = 8'(i + 1);
			exp[6 + 12 * i] = 8'h06;
			exp[11 + 12 * i] = 8'h04;
		end
		return 28;
	endfunction
	task automatic run_page(input logic [7:0] c, input logic [15:0] al, input logic [1:0] m);
		logic [31:0] d;
		logic [1:0]  r;
		int          n, i, k;
		n = build(c);
		if (al < n) n = al;
		mode <= m;
		clr  <= 1'b1;
		axi_wr(`VPR_A_CTRL, {al, c, 8'h03}, r);
		clr <= 1'b0;
		// Long stall so the FIFO fills and refuses before draining; mode 1 paces to the end
		if (m == 2'h2) begin
			repeat (40) @(posedge clk);
			mode <= 2'h0;
		end
		for (k = 0; k < 400 && seen_last !== 1'b1; k++) @(posedge clk);
		if (k == 400) hang;
		repeat (4) @(posedge clk);
		chk("byte count", 32'(n), 32'(cnt));
		for (i = 0; i < n; i++) chk("page byte", 32'(exp[i]), 32'(vpr_sink_inst.got[i]));
		axi_rd(`VPR_A_STATUS, d, r);
		chk("status", 32'h0000_0004, 32'(d[2:0]));
		axi_wr(`VPR_A_STATUS, 32'h0000_0004, r);
		axi_rd(`VPR_A_STATUS, d, r);
		chk("done clear", 32'h0000_0000, 32'(d[2:0]));
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		int          i;
		for (i = 0; i < 5; i++) begin
			axi_rd(`VPR_A_FLAGS + 12'(4 * i), d, r);
			chk("reset value", 32'h0000_0000, d);
			axi_wr(`VPR_A_FLAGS + 12'(4 * i), rv[i], r);
			chk("write resp", 32'h0000_0000, 32'(r));
			axi_rd(`VPR_A_FLAGS + 12'(4 * i), d, r);
			chk("read back", rv[i], d);
		end
		axi_wr(12'h0FC, 32'h0000_0001, r);
		chk("unmapped write", 32'h0000_0002, 32'(r));
		axi_rd(12'h0FC, d, r);
		chk("unmapped read", 32'h0000_0002, 32'(r));
		chk("unmapped data", 32'h0000_0000, d);
	endtask
	task automatic t_pages;
		run_page(8'h8A, 16'h0040, 2'h0);
		run_page(8'h8D, 16'h0008, 2'h1);
		run_page(8'h90, 16'h0040, 2'h2);
	endtask
	task automatic t_trunc;
		run_page(8'h90, 16'h0005, 2'h0);
		run_page(8'h8A, 16'h0011, 2'h1);
	endtask
	task automatic t_refuse;
		logic [31:0] d;
		logic [31:0] cv [0:2] = '{32'h0000_8A03, 32'h0040_8A01, 32'h0040_8B03};
		logic [1:0]  r;
		int          i;
		for (i = 0; i < 3; i++) begin
			clr <= 1'b1;
			axi_wr(`VPR_A_CTRL, cv[i], r);
			clr <= 1'b0;
			repeat (30) @(posedge clk);
			chk("refused bytes", 32'h0000_0000, 32'(cnt));
			axi_rd(`VPR_A_STATUS, d, r);
			chk("bad flag", 32'(i > 0), 32'(d[1]));
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_pages;
		t_trunc;
		t_refuse;
		finish_test;
	end
endmodule // test_vpr_page_responder
`default_nettype wire
